// File: rtl/acs_pkg.sv
/*
  Constants for the converter measurement sequencer: register offsets,
  field positions, reset values, slot and conversion timing.
  Assumes a 10 MHz mclk and a byte-wide register port.
*/
// Notes on behaviour
// - Five 128 us slots, repeated without end
// - Four inputs: supply, temperature, two user
// - Temperature always; others need enable bits
// - Automatic results keep eight top bits
// - Three low supply results set under flag
// - Supply paused until software clears flag
// - Unmasked set flags drive the interrupt
// - Three high temperature results set flag
// - Temperature paused until flag cleared by one
// - Calibration trim offset readable by software
// - User results land at their two offsets
// - User result outside window sets flag
// - User channel paused while its flag set
// - Debounce bit asks three consecutive violations
// - Bias off after user A, on slot before
// - Bias on after temperature conversion ends
// - Manual result split across two bytes
// - Run bit starts manual conversion, slot five
// - Manual completion stores result, sets flag
// - 1 MHz converter clock, 34 us per conversion
package acs_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ACS_OFS_AUTO  = 8'hE1; // Automatic control
  localparam logic [7:0] ACS_OFS_MAN   = 8'hE2; // Manual control
  localparam logic [7:0] ACS_OFS_DEB   = 8'hE3; // User debounce
  localparam logic [7:0] ACS_OFS_STAT  = 8'hE4; // Status flags
  localparam logic [7:0] ACS_OFS_CLR   = 8'hE5; // Flag clear
  localparam logic [7:0] ACS_OFS_MASK  = 8'hE6; // Interrupt mask
  localparam logic [7:0] ACS_OFS_MANLO = 8'hE7; // Manual result low
  localparam logic [7:0] ACS_OFS_MANHI = 8'hE8; // Manual result high
  localparam logic [7:0] ACS_OFS_SUPR  = 8'hE9; // Supply result
  localparam logic [7:0] ACS_OFS_TMPR  = 8'hEA; // Temperature result
  localparam logic [7:0] ACS_OFS_TRIM  = 8'hEB; // Calibration offset
  localparam logic [7:0] ACS_OFS_UAR   = 8'hEC; // User A result
  localparam logic [7:0] ACS_OFS_UALO  = 8'hED; // User A low limit
  localparam logic [7:0] ACS_OFS_UAHI  = 8'hEE; // User A high limit
  localparam logic [7:0] ACS_OFS_UBR   = 8'hEF; // User B result
  localparam logic [7:0] ACS_OFS_UBLO  = 8'hF0; // User B low limit
  localparam logic [7:0] ACS_OFS_UBHI  = 8'hF1; // User B high limit
  localparam logic [7:0] ACS_OFS_TTHR  = 8'hF2; // Temperature limit

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ACS_AC_SUP_EN  = 0; // Supply auto enable
  localparam int ACS_AC_UA_EN   = 1; // User A auto enable
  localparam int ACS_AC_UB_EN   = 2; // User B auto enable
  localparam int ACS_AC_BIAS_EN = 3; // User A bias enable
  localparam int ACS_MC_RUN     = 7; // Manual run
  localparam int ACS_MC_SEL_LO  = 0; // Manual channel select, 2 bits
  localparam int ACS_DB_UA      = 0; // User A debounce
  localparam int ACS_DB_UB      = 1; // User B debounce
  localparam int ACS_ST_SUP     = 0; // Supply under flag
  localparam int ACS_ST_TMP     = 1; // Over temperature flag
  localparam int ACS_ST_UA      = 2; // User A flag
  localparam int ACS_ST_UB      = 3; // User B flag
  localparam int ACS_ST_MAN     = 4; // Manual done flag

  // ---------------------------------------------------------------
  // Reset values and fixed thresholds
  // ---------------------------------------------------------------
  localparam logic [7:0] ACS_RST_MASK = 8'h1F; // All flags masked
  localparam logic [7:0] ACS_RST_HI   = 8'hFF; // High limits open
  localparam logic [7:0] ACS_RST_LO   = 8'h00; // Low limits open
  localparam logic [7:0] ACS_SUP_THR  = 8'h40; // Internal under level
  localparam logic [1:0] ACS_DEB_LONG = 2'h3;  // Debounced count
  localparam logic [1:0] ACS_DEB_ONE  = 2'h1;  // Single-shot count

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int ACS_CLK_KHZ   = 10000; // mclk rate
  localparam int ACS_SLOT_US   = 128;   // Slot period
  localparam int ACS_CONV_US   = 34;    // Total conversion time
  localparam int ACS_CCLK_KHZ  = 1000;  // Converter clock rate
  localparam int ACS_SLOT_CYC  = ACS_SLOT_US * ACS_CLK_KHZ / 1000;
  localparam int ACS_CONV_CYC  = ACS_CONV_US * ACS_CLK_KHZ / 1000;
  localparam int ACS_CCLK_HALF = ACS_CLK_KHZ / (2 * ACS_CCLK_KHZ);
  localparam logic [10:0] ACS_SLOT_LAST = 11'(ACS_SLOT_CYC - 1);
  localparam logic [8:0]  ACS_CONV_LAST = 9'(ACS_CONV_CYC - 1);
  localparam logic [2:0]  ACS_HALF_LAST = 3'(ACS_CCLK_HALF - 1);
  localparam logic [2:0]  ACS_SLOT_MAX  = 3'h4; // Fifth slot index

  // Sequencer phase
  typedef enum logic {ACS_IDLE, ACS_CONV} acs_phase_type;

endpackage

// File: rtl/acs_seq.sv
/*
  Measurement sequencer for a 10-bit converter with a four-way input
  multiplexer: slot schedule, threshold checks, flags, interrupt,
  user A bias timing and the byte register file.
  Assumes the analog core returns a done level and a result that are
  asynchronous to mclk and stay stable until the next start.
*/
`timescale 1ns/100ps
module acs_seq (
  input  wire logic       mclk,         // 10 MHz clock
  input  wire logic       nrst,         // Synchronous reset, low
  input  wire logic [7:0] reg_addr,     // Register offset
  input  wire logic [7:0] reg_wdata,    // Write data
  input  wire logic       reg_wr,       // Write strobe
  output logic      [7:0] reg_rdata,    // Read data, one cycle later
  input  wire logic       conv_done,    // Core done level
  input  wire logic [9:0] conv_result,  // Core result
  input  wire logic [7:0] trim_value,   // Stored calibration trim
  output logic            conv_clk,     // 1 MHz converter clock
  output logic            conv_start,   // Start pulse
  output logic      [1:0] conv_channel, // Multiplexer select
  output logic            bias_on,      // User A bias source on
  output logic            irq_n         // Interrupt, active low
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]          slot;     // Current slot
    logic [10:0]         tick;     // Cycle within slot
    acs_pkg::acs_phase_type phase; // Idle or converting
    logic [8:0]          wait_cnt; // Cycles in conversion
    logic [2:0]          div;      // Converter clock divider
    logic                cclk;     // Converter clock
    logic                start;    // Start pulse
    logic [1:0]          chan;     // Selected input
    logic [7:0]          auto_ctl; // Automatic control
    logic [7:0]          man_ctl;  // Manual control
    logic [7:0]          deb;      // Debounce enables
    logic [7:0]          mask;     // Interrupt mask
    logic [4:0]          status;   // Sticky flags
    logic [7:0]          res_sup;  // Supply result
    logic [7:0]          res_tmp;  // Temperature result
    logic [7:0]          res_ua;   // User A result
    logic [7:0]          res_ub;   // User B result
    logic [9:0]          res_man;  // Manual result
    logic [7:0]          thr_tmp;  // Temperature limit
    logic [7:0]          ua_lo;    // User A low limit
    logic [7:0]          ua_hi;    // User A high limit
    logic [7:0]          ub_lo;    // User B low limit
    logic [7:0]          ub_hi;    // User B high limit
    logic [1:0]          cnt_sup;  // Supply violation count
    logic [1:0]          cnt_tmp;  // Temperature violation count
    logic [1:0]          cnt_ua;   // User A violation count
    logic [1:0]          cnt_ub;   // User B violation count
    logic                bias;     // Bias source state
    logic                done_s1;  // Done sync stage 1
    logic                done_s2;  // Done sync stage 2
    logic                done_s3;  // Done edge history
    logic [9:0]          res_s1;   // Result sync stage 1
    logic [9:0]          res_s2;   // Result sync stage 2
    logic [7:0]          trim_s1;  // Trim sync stage 1
    logic [7:0]          trim_s2;  // Trim sync stage 2
    logic [7:0]          rdata;    // Read data
  } acs_state_type;

  acs_state_type s_q; // Registered state
  acs_state_type s_d; // Next state

  logic       done_rise; // Conversion finished
  logic [4:0] clr;       // Flag clear bits this cycle
  logic [4:0] set;       // Flag set bits this cycle

  // Debounce step: returns {set flag, next count}
  function automatic logic [2:0] acs_deb(input logic [1:0] cnt,
                                         input logic       bad,
                                         input logic [1:0] need);
    logic [1:0] n;
    n = 2'(cnt + 2'h1);
    if (!bad) begin
      acs_deb = 3'h0;               // Pass restarts count
    end else if (n >= need) begin
      acs_deb = {1'b1, 2'h0};       // Enough violations
    end else begin
      acs_deb = {1'b0, n};
    end
  endfunction

  // Edge of synchronised done
  assign done_rise = s_q.done_s2 & ~s_q.done_s3;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [2:0] r;
    logic       act;
    logic [1:0] sel;
    r   = 3'h0;
    act = 1'b0;
    sel = 2'h0;
    s_d = s_q;
    s_d.start = 1'b0;
    set = 5'h0;
    clr = 5'h0;

    // Two-stage synchronisers from the analog side
    s_d.done_s1 = conv_done;
    s_d.done_s2 = s_q.done_s1;
    s_d.done_s3 = s_q.done_s2;
    s_d.res_s1  = conv_result;
    s_d.res_s2  = s_q.res_s1;
    s_d.trim_s1 = trim_value;
    s_d.trim_s2 = s_q.trim_s1;

    // Converter clock divider
    if (s_q.div == acs_pkg::ACS_HALF_LAST) begin
      s_d.div  = 3'h0;
      s_d.cclk = ~s_q.cclk;
    end else begin
      s_d.div = 3'(s_q.div + 3'h1);
    end

    // Slot timer, endless cycle of five
    if (s_q.tick == acs_pkg::ACS_SLOT_LAST) begin
      s_d.tick = 11'h0;
      if (s_q.slot == acs_pkg::ACS_SLOT_MAX) begin
        s_d.slot = 3'h0;
      end else begin
        s_d.slot = 3'(s_q.slot + 3'h1);
      end
    end else begin
      s_d.tick = 11'(s_q.tick + 11'h1);
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        acs_pkg::ACS_OFS_AUTO: s_d.auto_ctl = reg_wdata;
        acs_pkg::ACS_OFS_MAN:  s_d.man_ctl  = reg_wdata;
        acs_pkg::ACS_OFS_DEB:  s_d.deb      = reg_wdata;
        acs_pkg::ACS_OFS_MASK: s_d.mask     = reg_wdata;
        acs_pkg::ACS_OFS_CLR:  clr          = reg_wdata[4:0];
        acs_pkg::ACS_OFS_TTHR: s_d.thr_tmp  = reg_wdata;
        acs_pkg::ACS_OFS_UALO: s_d.ua_lo    = reg_wdata;
        acs_pkg::ACS_OFS_UAHI: s_d.ua_hi    = reg_wdata;
        acs_pkg::ACS_OFS_UBLO: s_d.ub_lo    = reg_wdata;
        acs_pkg::ACS_OFS_UBHI: s_d.ub_hi    = reg_wdata;
        default: ;             // Read-only or unmapped
      endcase
    end

    // Slot admission: enable, pause and request
    case (s_q.slot)
      3'h0: begin
        act = s_q.auto_ctl[acs_pkg::ACS_AC_SUP_EN]
              & ~s_q.status[acs_pkg::ACS_ST_SUP];
        sel = 2'h0;
      end
      3'h1: begin
        act = ~s_q.status[acs_pkg::ACS_ST_TMP];
        sel = 2'h1;
      end
      3'h2: begin
        act = s_q.auto_ctl[acs_pkg::ACS_AC_UA_EN]
              & ~s_q.status[acs_pkg::ACS_ST_UA];
        sel = 2'h2;
      end
      3'h3: begin
        act = s_q.auto_ctl[acs_pkg::ACS_AC_UB_EN]
              & ~s_q.status[acs_pkg::ACS_ST_UB];
        sel = 2'h3;
      end
      default: begin
        act = s_q.man_ctl[acs_pkg::ACS_MC_RUN]
              & ~s_q.status[acs_pkg::ACS_ST_MAN];
        sel = s_q.man_ctl[acs_pkg::ACS_MC_SEL_LO +: 2];
      end
    endcase

    // Conversion control
    case (s_q.phase)
      acs_pkg::ACS_IDLE: begin
        // Start at the head of an admitted slot
        if (s_q.tick == 11'h0 && act) begin
          s_d.start    = 1'b1;
          s_d.chan     = sel;
          s_d.phase    = acs_pkg::ACS_CONV;
          s_d.wait_cnt = 9'h0;
          if (s_q.slot == acs_pkg::ACS_SLOT_MAX) begin
            s_d.man_ctl[acs_pkg::ACS_MC_RUN] = 1'b0; // One shot
          end
        end
      end
      acs_pkg::ACS_CONV: begin
        if (done_rise) begin
          s_d.phase = acs_pkg::ACS_IDLE;
          if (s_q.slot == acs_pkg::ACS_SLOT_MAX) begin
            s_d.res_man = s_q.res_s2;
            set[acs_pkg::ACS_ST_MAN] = 1'b1;
          end else begin
            case (s_q.chan)
              2'h0: begin
                s_d.res_sup = s_q.res_s2[9:2];
                r = acs_deb(s_q.cnt_sup,
                            s_q.res_s2[9:2] < acs_pkg::ACS_SUP_THR,
                            acs_pkg::ACS_DEB_LONG);
                s_d.cnt_sup = r[1:0];
                set[acs_pkg::ACS_ST_SUP] = r[2];
              end
              2'h1: begin
                s_d.res_tmp = s_q.res_s2[9:2];
                r = acs_deb(s_q.cnt_tmp,
                            s_q.res_s2[9:2] > s_q.thr_tmp,
                            acs_pkg::ACS_DEB_LONG);
                s_d.cnt_tmp = r[1:0];
                set[acs_pkg::ACS_ST_TMP] = r[2];
              end
              2'h2: begin
                s_d.res_ua = s_q.res_s2[9:2];
                r = acs_deb(s_q.cnt_ua,
                            s_q.res_s2[9:2] < s_q.ua_lo
                            || s_q.res_s2[9:2] > s_q.ua_hi,
                            s_q.deb[acs_pkg::ACS_DB_UA]
                            ? acs_pkg::ACS_DEB_LONG
                            : acs_pkg::ACS_DEB_ONE);
                s_d.cnt_ua = r[1:0];
                set[acs_pkg::ACS_ST_UA] = r[2];
              end
              default: begin
                s_d.res_ub = s_q.res_s2[9:2];
                r = acs_deb(s_q.cnt_ub,
                            s_q.res_s2[9:2] < s_q.ub_lo
                            || s_q.res_s2[9:2] > s_q.ub_hi,
                            s_q.deb[acs_pkg::ACS_DB_UB]
                            ? acs_pkg::ACS_DEB_LONG
                            : acs_pkg::ACS_DEB_ONE);
                s_d.cnt_ub = r[1:0];
                set[acs_pkg::ACS_ST_UB] = r[2];
              end
            endcase
          end
        end else if (s_q.wait_cnt == acs_pkg::ACS_CONV_LAST) begin
          s_d.phase = acs_pkg::ACS_IDLE;  // No answer: drop
        end else begin
          s_d.wait_cnt = 9'(s_q.wait_cnt + 9'h1);
        end
      end
      default: s_d.phase = acs_pkg::ACS_IDLE;
    endcase

    // Sticky flags, set wins over clear
    s_d.status = (s_q.status & ~clr) | set;

    // Count restart on clear or disable
    if (clr[acs_pkg::ACS_ST_SUP]
        || !s_q.auto_ctl[acs_pkg::ACS_AC_SUP_EN]) begin
      s_d.cnt_sup = 2'h0;
    end
    if (clr[acs_pkg::ACS_ST_TMP]) begin
      s_d.cnt_tmp = 2'h0;
    end
    if (clr[acs_pkg::ACS_ST_UA]
        || !s_q.auto_ctl[acs_pkg::ACS_AC_UA_EN]) begin
      s_d.cnt_ua = 2'h0;
    end
    if (clr[acs_pkg::ACS_ST_UB]
        || !s_q.auto_ctl[acs_pkg::ACS_AC_UB_EN]) begin
      s_d.cnt_ub = 2'h0;
    end

    // User A bias timing
    if (!s_q.auto_ctl[acs_pkg::ACS_AC_BIAS_EN]) begin
      s_d.bias = 1'b0;
    end else if (s_q.slot == 3'h2 && s_q.phase == acs_pkg::ACS_CONV
                 && done_rise) begin
      s_d.bias = 1'b0;
    end else if (s_q.slot == 3'h1
                 && (s_q.status[acs_pkg::ACS_ST_TMP]
                     || (s_q.phase == acs_pkg::ACS_CONV
                         && done_rise))) begin
      s_d.bias = 1'b1;
    end

    // Read data mux
    case (reg_addr)
      acs_pkg::ACS_OFS_AUTO:  s_d.rdata = s_q.auto_ctl;
      acs_pkg::ACS_OFS_MAN:   s_d.rdata = s_q.man_ctl;
      acs_pkg::ACS_OFS_DEB:   s_d.rdata = s_q.deb;
      acs_pkg::ACS_OFS_STAT:  s_d.rdata = {3'h0, s_q.status};
      acs_pkg::ACS_OFS_MASK:  s_d.rdata = s_q.mask;
      acs_pkg::ACS_OFS_MANLO: s_d.rdata = {6'h0, s_q.res_man[1:0]};
      acs_pkg::ACS_OFS_MANHI: s_d.rdata = s_q.res_man[9:2];
      acs_pkg::ACS_OFS_SUPR:  s_d.rdata = s_q.res_sup;
      acs_pkg::ACS_OFS_TMPR:  s_d.rdata = s_q.res_tmp;
      acs_pkg::ACS_OFS_TRIM:  s_d.rdata = s_q.trim_s2;
      acs_pkg::ACS_OFS_UAR:   s_d.rdata = s_q.res_ua;
      acs_pkg::ACS_OFS_UALO:  s_d.rdata = s_q.ua_lo;
      acs_pkg::ACS_OFS_UAHI:  s_d.rdata = s_q.ua_hi;
      acs_pkg::ACS_OFS_UBR:   s_d.rdata = s_q.res_ub;
      acs_pkg::ACS_OFS_UBLO:  s_d.rdata = s_q.ub_lo;
      acs_pkg::ACS_OFS_UBHI:  s_d.rdata = s_q.ub_hi;
      acs_pkg::ACS_OFS_TTHR:  s_d.rdata = s_q.thr_tmp;
      default:                s_d.rdata = 8'h00;           // Flag clear or unmapped
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q         <= '0;
      s_q.mask    <= acs_pkg::ACS_RST_MASK;
      s_q.thr_tmp <= acs_pkg::ACS_RST_HI;
      s_q.ua_hi   <= acs_pkg::ACS_RST_HI;
      s_q.ub_hi   <= acs_pkg::ACS_RST_HI;
      s_q.ua_lo   <= acs_pkg::ACS_RST_LO;
      s_q.ub_lo   <= acs_pkg::ACS_RST_LO;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign reg_rdata    = s_q.rdata;
  assign conv_clk     = s_q.cclk;
  assign conv_start   = s_q.start;
  assign conv_channel = s_q.chan;
  assign bias_on      = s_q.bias;
  assign irq_n        = ~|(s_q.status & ~s_q.mask[4:0]);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence seq_head(logic [2:0] n);
    s_q.slot == n && s_q.tick == 11'h0 && s_q.phase == acs_pkg::ACS_IDLE;
  endsequence

  sequence seq_done(logic [2:0] n);
    s_q.phase == acs_pkg::ACS_CONV && done_rise && s_q.slot == n;
  endsequence

  a_slot_wrap: assert property (
    s_q.slot == acs_pkg::ACS_SLOT_MAX
    && s_q.tick == acs_pkg::ACS_SLOT_LAST
    |=> s_q.slot == 3'h0 && s_q.tick == 11'h0)
    else $error("slot sequence did not wrap");

  a_slot_hold: assert property (
    s_q.tick == 11'h0 |=> $stable(s_q.slot)[*8])
    else $error("slot changed early");

  a_temp_start: assert property (
    seq_head(3'h1) ##0 !s_q.status[acs_pkg::ACS_ST_TMP]
    |=> conv_start && conv_channel == 2'h1)
    else $error("temperature conversion missing");

  a_supply_pause: assert property (
    seq_head(3'h0) ##0 s_q.status[acs_pkg::ACS_ST_SUP] |=> !conv_start)
    else $error("supply converted while flagged");

  a_user_pause: assert property (
    seq_head(3'h2) ##0 (s_q.status[acs_pkg::ACS_ST_UA]
    || !s_q.auto_ctl[acs_pkg::ACS_AC_UA_EN]) |=> !conv_start)
    else $error("user A converted while paused");

  a_auto_result: assert property (
    seq_done(3'h2) |=> s_q.res_ua == $past(s_q.res_s2[9:2]))
    else $error("user A result not stored");

  a_man_done: assert property (
    seq_done(acs_pkg::ACS_SLOT_MAX) |=> s_q.status[acs_pkg::ACS_ST_MAN]
    && s_q.res_man == $past(s_q.res_s2))
    else $error("manual completion lost");

  a_bias_off: assert property (
    seq_done(3'h2) |=> !bias_on)
    else $error("bias stayed on after user A");

  a_irq_level: assert property (
    $rose(s_q.status[acs_pkg::ACS_ST_TMP])
    && !s_q.mask[acs_pkg::ACS_ST_TMP] |-> !irq_n)
    else $error("unmasked flag gave no interrupt");

  a_cclk_rate: assert property (
    $changed(conv_clk) |=> $stable(conv_clk)[*4] ##1 $changed(conv_clk))
    else $error("converter clock not 1 MHz");

endmodule

// File: verif/acs_core_model.sv
/* Behavioural converter core with its input multiplexer.
   Assumes one start pulse per conversion and a per-channel result table. */
`timescale 1ns/100ps
module acs_core_model #(
  parameter int DLY = 300 // Conversion latency in mclk cycles
) (
  input  wire logic        mclk,         // Sequencer clock
  input  wire logic        conv_start,   // Start pulse
  input  wire logic [1:0]  conv_channel, // Multiplexer select
  input  wire logic [39:0] results,      // Result per channel, ch0 low
  output logic             conv_done,    // Done level
  output logic       [9:0] conv_result   // Result, stable while done
);
  logic [1:0] ch_q;  // Latched channel
  int         cnt_q; // Cycles to done
  initial begin
    conv_done = 1'b0;
    conv_result = 10'h000;
    cnt_q = 0;
  end
  // Latch the channel; result shows junk until done rises
  always @(posedge mclk) begin
    if (conv_start) begin
      ch_q <= conv_channel;
      cnt_q <= DLY;
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == 1) begin
        conv_done <= 1'b1;
        conv_result <= results[ch_q*10 +: 10];
      end
    end
  end
endmodule

// File: verif/test_adc_measurement_sequencer.sv
/* Bench for the sequencer: flags, pausing, interrupt, manual run.
   Assumes the core model is compiled first. */
`timescale 1ns/100ps
module test_adc_measurement_sequencer;
  logic       mclk, nrst, reg_wr, conv_done, conv_clk, conv_start;
  logic       bias_on, irq_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic [9:0] conv_result;
  logic [1:0] conv_channel;
  int         miscompares, check_count, st[4];
  // Results for ch3..ch0
  localparam logic [39:0] RES = {10'h041, 10'h2FF, 10'h300, 10'h0FC};
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  acs_seq acs_seq_i (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .conv_result(conv_result),
    .trim_value(8'h5A), .conv_clk(conv_clk), .conv_start(conv_start),
    .conv_channel(conv_channel), .bias_on(bias_on), .irq_n(irq_n));
  acs_core_model acs_core_model_i (.mclk(mclk), .conv_start(conv_start),
    .conv_channel(conv_channel), .results(RES), .conv_done(conv_done),
    .conv_result(conv_result));
  // Count starts per channel
  always @(posedge mclk) begin
    if (conv_start === 1'b1) st[conv_channel]++;
  end
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rdr(logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    rd = reg_rdata;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Reset values, trim and an unmapped offset
  task automatic sc_reset;
    rdr(8'hE6);
    check("mask", rd, 8'h1F);
    rdr(8'hF5);
    check("unmapped", rd, 8'h00);
    rdr(8'hEB);
    check("trim", rd, 8'h5A);
    check("irq", {7'h00, irq_n}, 8'h01);
  endtask
  // Six rounds of automatic slots with all channels out of range
  task automatic sc_auto;
    wr(8'hF2, 8'h10);
    wr(8'hEE, 8'h80);
    wr(8'hF0, 8'h20);
    wr(8'hE3, 8'h02);
    wr(8'hE1, 8'h07);
    repeat (38400) @(negedge mclk);
    check("sup starts", 8'(st[0]), 8'h03);
    check("tmp starts", 8'(st[1]), 8'h03);
    check("ua starts", 8'(st[2]), 8'h01);
    check("ub starts", 8'(st[3]), 8'h03);
    rdr(8'hE9);
    check("sup res", rd, 8'h3F);
    rdr(8'hEA);
    check("tmp res", rd, 8'hC0);
    rdr(8'hEC);
    check("ua res", rd, 8'hBF);
    rdr(8'hEF);
    check("ub res", rd, 8'h10);
    rdr(8'hE4);
    check("status", rd, 8'h0F);
    check("irq masked", {7'h00, irq_n}, 8'h01);
    wr(8'hE6, 8'h00);
    check("irq open", {7'h00, irq_n}, 8'h00);
    wr(8'hE5, 8'h0F);
    rdr(8'hE4);
    check("cleared", rd, 8'h00);
    check("irq gone", {7'h00, irq_n}, 8'h01);
  endtask
  // Manual conversion on user channel B
  task automatic sc_manual;
    int n;
    wr(8'hE1, 8'h00);
    wr(8'hE6, 8'h0F);
    wr(8'hE2, 8'h83);
    n = 0;
    while (irq_n !== 1'b0 && n < 7000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 7000) begin
      miscompares++;
      wrap_up();
    end
    rdr(8'hE8);
    check("man hi", rd, 8'h10);
    rdr(8'hE7);
    check("man lo", rd, 8'h01);
    rdr(8'hE4);
    check("man flag", rd, 8'h10);
    wr(8'hE5, 8'h10);
    check("man irq", {7'h00, irq_n}, 8'h01);
  endtask
  // Converter clock high time, then user A bias on and off
  task automatic sc_bias;
    int n;
    n = 0;
    while (conv_clk !== 1'b0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    while (conv_clk !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (conv_clk === 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    check("cclk high", 8'(n), 8'h05);
    wr(8'hE1, 8'h0A);
    n = 0;
    while (bias_on !== 1'b1 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    check("bias on seen", {7'h00, bias_on}, 8'h01);
    check("bias on ch", {6'h00, conv_channel}, 8'h01);
    check("bias on done", {7'h00, conv_done}, 8'h01);
    n = 0;
    while (bias_on !== 1'b0 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    check("bias off seen", {7'h00, bias_on}, 8'h00);
    check("bias off ch", {6'h00, conv_channel}, 8'h02);
    check("bias off done", {7'h00, conv_done}, 8'h01);
  endtask
  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    sc_reset();
    sc_auto();
    sc_manual();
    sc_bias();
    wrap_up();
  end
endmodule
